// [inc/timer_pkg.sv]
// constants, register map and phase type for the 8-bit timer/prescaler
package timer_pkg;

  localparam int TIMER_W   = 8;
  localparam int PRE_W     = 8;
  localparam int RATE_W    = 3;
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 12;
  localparam int PORTA_W   = 6;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_COUNT      = 8'h01;
  localparam logic [7:0] IDX_INTERRUPT_CTRL   = 8'h0B;
  localparam logic [7:0] IDX_OPTION_CTRL      = 8'h81;
  localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] IDX_IRQ_STATUS       = 8'hC0;
  localparam logic [7:0] IDX_IRQ_CLEAR        = 8'hC1;
  localparam logic [7:0] IDX_IRQ_ENABLE       = 8'hC2;

  localparam logic [ADDR_W-1:0] ADDR_TIMER_COUNT      =
    {2'h0, IDX_TIMER_COUNT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_CTRL   =
    {2'h0, IDX_INTERRUPT_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_OPTION_CTRL      =
    {2'h0, IDX_OPTION_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PORT_A_DIRECTION =
    {2'h0, IDX_PORT_A_DIRECTION, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS       =
    {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR        =
    {2'h0, IDX_IRQ_CLEAR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE       =
    {2'h0, IDX_IRQ_ENABLE, 2'h0};

  // option register fields
  localparam int OPT_SOURCE_BIT = 5;
  localparam int OPT_EDGE_BIT   = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATE_LSB   = 0;

  // interrupt control fields
  localparam int INTC_FLAG_BIT   = 2;
  localparam int INTC_ENABLE_BIT = 5;
  localparam int IRQ_OVERFLOW_BIT = 0;

  localparam logic [7:0]         RST_TIMER_COUNT = 8'h00;
  localparam logic [7:0]         RST_INTC        = 8'h00;
  localparam logic [7:0]         RST_OPTION      = 8'hFF;
  localparam logic [PORTA_W-1:0] RST_PORT_A_DIR  = 6'h3F;

  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // instruction cycles for which a count write blocks counting
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

  typedef enum logic [3:0] {
    phase_q1 = 4'h1,
    phase_q2 = 4'h2,
    phase_q3 = 4'h4,
    phase_q4 = 4'h8
  } qphase_t;

endpackage : timer_pkg

// [hdl/eight_bit_timer_prescaler.sv]
// 8-bit timer/counter with shared watchdog prescaler and APB registers
//
// Overview of operation
// - internal source counts every instruction cycle
// - count write blocks counting two instruction cycles
// - external source counts selected pin edges
// - edge bit set falling, clear rising
// - rollover from max to zero sets flag
// - interrupt gated by enable; flag sticky
// - counter halted during sleep
// - counter input sampled on Q2 and Q4
// - unscaled external input feeds counter directly
// - assign bit routes prescaler watchdog or timer
// - timer prescale two to rate plus one
// - watchdog prescale two to the rate
// - prescaler is hidden eight-bit counter
// - count write clears timer-assigned prescaler
// - watchdog clear also clears assigned prescaler
module eight_bit_timer_prescaler #(
  parameter int TIMER_W = timer_pkg::TIMER_W,
  parameter int PRE_W   = timer_pkg::PRE_W
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [timer_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [timer_pkg::DATA_W-1:0]  pwdata,
  output logic      [timer_pkg::DATA_W-1:0]  prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          external_count_pin,
  input  wire logic                          sleep_mode,
  input  wire logic                          clear_watchdog_instruction,
  input  wire logic                          watchdog_time_base,
  output logic                               watchdog_tick,
  output logic                               watchdog_clear,
  output logic                               instr_cycle,
  output logic                               irq,
  output logic      [timer_pkg::PORTA_W-1:0] port_a_direction
);

  logic [TIMER_W-1:0]            timer_count;
  logic [7:0]                    interrupt_control;
  logic [7:0]                    timer_option_control;
  logic [PRE_W-1:0]              prescaler;
  logic [1:0]                    inhibit_cnt;
  logic                          pending;
  logic                          ext_meta;
  logic                          ext_sync;
  logic                          ext_prev;
  timer_pkg::qphase_t            phase;
  timer_pkg::qphase_t            next_phase;
  logic [7:0]                    next_intc;
  logic [timer_pkg::DATA_W-1:0]  next_rdata;

  // divide-by-field mask: low (rate + extra) bits set
  function automatic logic [PRE_W-1:0] rate_mask(
    input logic [timer_pkg::RATE_W-1:0] rate,
    input logic                         extra
  );
    logic [PRE_W:0]             m;
    logic [timer_pkg::RATE_W:0] sh;
    // one bit wider so that rate 7 plus one still reaches eight
    sh = {1'b0, rate} + {{timer_pkg::RATE_W{1'b0}}, extra};
    m  = ({{PRE_W{1'b0}}, 1'b1} << sh) - 1'b1;
    return m[PRE_W-1:0];
  endfunction : rate_mask

  function automatic logic addr_is(
    input logic [timer_pkg::ADDR_W-1:0] a,
    input logic [timer_pkg::ADDR_W-1:0] reg_addr
  );
    return a == reg_addr;
  endfunction : addr_is

  // option and interrupt control fields
  wire                          src_external =
    timer_option_control[timer_pkg::OPT_SOURCE_BIT];
  wire                          edge_falling =
    timer_option_control[timer_pkg::OPT_EDGE_BIT];
  wire                          to_watchdog  =
    timer_option_control[timer_pkg::OPT_ASSIGN_BIT];
  wire [timer_pkg::RATE_W-1:0]  rate_field   =
    timer_option_control[timer_pkg::OPT_RATE_LSB +: timer_pkg::RATE_W];
  wire                          ovf_flag     =
    interrupt_control[timer_pkg::INTC_FLAG_BIT];
  wire                          ovf_enable   =
    interrupt_control[timer_pkg::INTC_ENABLE_BIT];

  // apb decode
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire hit_cnt  = addr_is(paddr, timer_pkg::ADDR_TIMER_COUNT);
  wire hit_intc = addr_is(paddr, timer_pkg::ADDR_INTERRUPT_CTRL);
  wire hit_opt  = addr_is(paddr, timer_pkg::ADDR_OPTION_CTRL);
  wire hit_dir  = addr_is(paddr, timer_pkg::ADDR_PORT_A_DIRECTION);
  wire hit_sts  = addr_is(paddr, timer_pkg::ADDR_IRQ_STATUS);
  wire hit_clr  = addr_is(paddr, timer_pkg::ADDR_IRQ_CLEAR);
  wire hit_ena  = addr_is(paddr, timer_pkg::ADDR_IRQ_ENABLE);
  wire hit_any  = hit_cnt | hit_intc | hit_opt | hit_dir |
                  hit_sts | hit_clr | hit_ena;
  wire wr_cnt   = wr & hit_cnt;
  wire wr_intc  = wr & hit_intc;
  wire wr_opt   = wr & hit_opt;
  wire wr_dir   = wr & hit_dir;
  wire wr_clr   = wr & hit_clr;
  wire wr_ena   = wr & hit_ena;

  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  // instruction cycle phases
  wire q2_strobe = (phase == timer_pkg::phase_q2);
  wire q4_strobe = (phase == timer_pkg::phase_q4);
  wire sample    = q2_strobe | q4_strobe;

  always_comb begin
    case (phase)
      timer_pkg::phase_q1: next_phase = timer_pkg::phase_q2;
      timer_pkg::phase_q2: next_phase = timer_pkg::phase_q3;
      timer_pkg::phase_q3: next_phase = timer_pkg::phase_q4;
      timer_pkg::phase_q4: next_phase = timer_pkg::phase_q1;
      default:             next_phase = timer_pkg::phase_q1;
    endcase
  end

  // pin edge detection after the synchroniser
  wire rise_edge = ext_sync & ~ext_prev;
  wire fall_edge = ~ext_sync & ext_prev;
  wire ext_edge  = edge_falling ? fall_edge : rise_edge;

  // counter source, halted in sleep
  wire timer_src = ~sleep_mode &
                   (src_external ? ext_edge : q4_strobe);

  // shared prescaler
  wire             pre_in    = to_watchdog ? watchdog_time_base
                                           : timer_src;
  wire [PRE_W-1:0] pre_mask  = rate_mask(rate_field, ~to_watchdog);
  wire             pre_out   = pre_in & ((prescaler & pre_mask) == pre_mask);
  wire             pre_clear = (to_watchdog & clear_watchdog_instruction) |
                               (~to_watchdog & wr_cnt);

  // event reaching the counter and the actual increment
  wire timer_evt = to_watchdog ? timer_src : pre_out;
  wire incr      = pending & sample & ~sleep_mode &
                   (inhibit_cnt == 2'h0);
  // a count write wins over the increment, so no rollover then
  wire overflow  = incr & ~wr_cnt &
                   (timer_count == timer_pkg::COUNT_MAX);

  // interrupt control; hardware set wins over software clear
  always_comb begin
    next_intc = interrupt_control;
    if (wr_intc) begin
      next_intc = pwdata[7:0];
    end
    if (wr_ena) begin
      next_intc[timer_pkg::INTC_ENABLE_BIT] =
        pwdata[timer_pkg::IRQ_OVERFLOW_BIT];
    end
    if (wr_clr && pwdata[timer_pkg::IRQ_OVERFLOW_BIT]) begin
      next_intc[timer_pkg::INTC_FLAG_BIT] = 1'b0;
    end
    if (overflow) begin
      next_intc[timer_pkg::INTC_FLAG_BIT] = 1'b1;
    end
  end

  assign irq = ovf_flag & ovf_enable;

  // read data, captured in the setup phase
  always_comb begin
    next_rdata = '0;
    if (hit_cnt) begin
      next_rdata[TIMER_W-1:0] = timer_count;
    end
    if (hit_intc) begin
      next_rdata[7:0] = interrupt_control;
    end
    if (hit_opt) begin
      next_rdata[7:0] = timer_option_control;
    end
    if (hit_dir) begin
      next_rdata[timer_pkg::PORTA_W-1:0] = port_a_direction;
    end
    if (hit_sts) begin
      next_rdata[timer_pkg::IRQ_OVERFLOW_BIT] = ovf_flag;
    end
    if (hit_ena) begin
      next_rdata[timer_pkg::IRQ_OVERFLOW_BIT] = ovf_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= external_count_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= timer_pkg::phase_q1;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_option_control <= timer_pkg::RST_OPTION;
      port_a_direction     <= timer_pkg::RST_PORT_A_DIR;
      interrupt_control    <= timer_pkg::RST_INTC;
    end else begin
      interrupt_control <= next_intc;
      if (wr_opt) begin
        timer_option_control <= pwdata[7:0];
      end
      if (wr_dir) begin
        port_a_direction <= pwdata[timer_pkg::PORTA_W-1:0];
      end
    end
  end

  // hidden prescaler, no bus path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler <= '0;
    end else if (pre_clear) begin
      prescaler <= '0;
    end else if (pre_in) begin
      prescaler <= prescaler + 1'b1;
    end
  end

  // event waits for the next Q2 or Q4 sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
    end else begin
      pending <= timer_evt | (pending & ~sample);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_cnt <= 2'h0;
    end else if (wr_cnt) begin
      inhibit_cnt <= timer_pkg::INHIBIT_CYCLES;
    end else if (q4_strobe && inhibit_cnt != 2'h0) begin
      inhibit_cnt <= inhibit_cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= timer_pkg::RST_TIMER_COUNT;
    end else if (wr_cnt) begin
      timer_count <= pwdata[TIMER_W-1:0];
    end else if (incr) begin
      timer_count <= timer_count + 1'b1;
    end
  end

  // watchdog side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_tick  <= 1'b0;
      watchdog_clear <= 1'b0;
      instr_cycle    <= 1'b0;
    end else begin
      watchdog_tick  <= to_watchdog ? pre_out : watchdog_time_base;
      watchdog_clear <= clear_watchdog_instruction;
      instr_cycle    <= q4_strobe;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_count_write;
    wr_cnt;
  endsequence

  sequence seq_no_count;
    !incr [*5];
  endsequence

  a_write_inhibit: assert property (
    seq_count_write |=> seq_no_count)
    else $error("count advanced right after a count write");

  a_write_loads: assert property (
    seq_count_write |=> timer_count == $past(pwdata[TIMER_W-1:0]))
    else $error("count write did not load value");

  a_overflow_flag: assert property (
    incr && !wr_cnt && timer_count == timer_pkg::COUNT_MAX
      |=> ovf_flag && timer_count == '0)
    else $error("rollover did not set the flag");

  a_flag_sticky: assert property (
    ovf_flag && !wr_intc && !wr_clr |=> ovf_flag)
    else $error("overflow flag dropped without software");

  a_irq_masked: assert property (
    !ovf_enable |-> !irq)
    else $error("interrupt raised while disabled");

  a_sleep_halts: assert property (
    sleep_mode && !wr_cnt |=> timer_count == $past(timer_count))
    else $error("count moved during sleep");

  a_sample_phase: assert property (
    incr |-> phase == timer_pkg::phase_q2 || phase == timer_pkg::phase_q4)
    else $error("count advanced outside Q2 or Q4");

  a_ext_direct: assert property (
    to_watchdog && src_external && ext_edge && !sleep_mode |=> pending)
    else $error("external edge lost without prescaler");

  a_pre_clear_tmr: assert property (
    wr_cnt && !to_watchdog |=> prescaler == '0)
    else $error("count write left prescaler running");

  a_pre_clear_wdt: assert property (
    clear_watchdog_instruction && to_watchdog
      |=> prescaler == '0 && watchdog_clear)
    else $error("watchdog clear left prescaler running");

  a_wdt_unity: assert property (
    to_watchdog && rate_field == '0 && watchdog_time_base
      |=> watchdog_tick)
    else $error("watchdog 1:1 rate lost a tick");

  a_count_step: assert property (
    incr && !wr_cnt
      |=> timer_count == TIMER_W'($past(timer_count) + 1'b1))
    else $error("count did not advance by one");

  a_sleep_no_flag: assert property (
    sleep_mode && !ovf_flag && !wr_intc |=> !ovf_flag)
    else $error("overflow flag set during sleep");

  a_pre_no_back: assert property (
    !to_watchdog && pre_out && !wr_opt |=> !pre_out)
    else $error("timer prescaler passed two events in a row");

  a_read_count: assert property (
    psel && !penable && !pwrite && hit_cnt
      |=> prdata[TIMER_W-1:0] == $past(timer_count))
    else $error("count read returned a stale value");

  a_wdt_bypass: assert property (
    !to_watchdog |=> watchdog_tick == $past(watchdog_time_base))
    else $error("watchdog tick not bypassed with timer prescaler");

endmodule : eight_bit_timer_prescaler

// [bench/count_source.sv]
// external count source model for the timer clock pin
module count_source (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [7:0] toggles,
  input  wire logic [3:0] half,
  output logic            pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  logic [3:0] cnt;
  assign busy = (left != 8'h00);
  // pin rests at its last level between bursts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin  <= 1'b0;
      left <= 8'h00;
      cnt  <= 4'h0;
    end else if (start && left == 8'h00) begin
      left <= toggles;
      cnt  <= half;
    end else if (left != 8'h00) begin
      if (cnt <= 4'h1) begin
        pin  <= ~pin;
        left <= left - 8'h01;
        cnt  <= half;
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : count_source

// [bench/tb.sv]
// self-checking bench for the 8-bit timer with shared prescaler
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       rd;
    logic       err;
  } note_t;
  localparam logic [11:0] A_CNT   = timer_pkg::ADDR_TIMER_COUNT;
  localparam logic [11:0] A_INTC  = timer_pkg::ADDR_INTERRUPT_CTRL;
  localparam logic [11:0] A_OPT   = timer_pkg::ADDR_OPTION_CTRL;
  localparam logic [11:0] A_PORTA = timer_pkg::ADDR_PORT_A_DIRECTION;
  localparam logic [11:0] A_STAT  = timer_pkg::ADDR_IRQ_STATUS;
  localparam logic [11:0] A_CLR   = timer_pkg::ADDR_IRQ_CLEAR;
  localparam logic [11:0] A_EN    = timer_pkg::ADDR_IRQ_ENABLE;
  localparam logic [11:0] A_BAD   = 12'h3FC;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_pin;
  logic        sleep_mode;
  logic        cwi;
  logic        wd_base;
  logic        wd_tick;
  logic        wd_clear;
  logic        irq;
  logic        icyc;
  logic [5:0]  porta;
  logic        src_start;
  logic        src_busy;
  logic [7:0]  src_tog;
  logic [3:0]  src_half;
  note_t       notes[$];
  note_t       cur;
  int          err_total;
  int          compares;
  int          ticks;
  int          clears;

  eight_bit_timer_prescaler eight_bit_timer_prescaler_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_pin(ext_pin),
    .sleep_mode(sleep_mode), .clear_watchdog_instruction(cwi),
    .watchdog_time_base(wd_base), .watchdog_tick(wd_tick),
    .watchdog_clear(wd_clear), .instr_cycle(icyc), .irq(irq),
    .port_a_direction(porta)
  );
  count_source count_source_inst (
    .pclk(pclk), .presetn(presetn), .start(src_start),
    .toggles(src_tog), .half(src_half), .pin(ext_pin), .busy(src_busy)
  );

  task automatic finish_test();
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic check_rsp(input note_t n, input logic [31:0] d,
                           input logic e);
    compares++;
    if (e !== n.err || (n.rd && !((d[31:8] === 24'h0) &&
        (d[7:0] >= n.lo) === 1'b1 && (d[7:0] <= n.hi) === 1'b1))) begin
      err_total++;
      $display("FAIL %0t bus response %h", $time, d);
    end
  endtask : check_rsp

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input note_t n);
    @(posedge pclk);
    notes.push_back(n);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, '{8'h00, 8'h00, 1'b0, 1'b0});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] lo,
                    input logic [7:0] hi);
    apb(1'b0, a, 32'h0, '{lo, hi, 1'b1, 1'b0});
  endtask : rd

  task automatic irq_is(input logic e);
    @(negedge pclk);
    check_val({7'h00, irq}, {7'h00, e});
  endtask : irq_is

  task automatic wdb(input int n);
    repeat (n) begin
      @(posedge pclk);
      wd_base <= 1'b1;
      @(posedge pclk);
      wd_base <= 1'b0;
    end
  endtask : wdb

  task automatic wdt_clear();
    @(posedge pclk);
    cwi <= 1'b1;
    @(posedge pclk);
    cwi <= 1'b0;
  endtask : wdt_clear

  task automatic ext_case(input logic [7:0] o, input logic [7:0] n,
                          input logic [7:0] e);
    wdt_clear();
    wr(A_OPT, o);
    wr(A_CNT, 8'h00);
    repeat (12) @(posedge pclk);
    @(posedge pclk);
    src_tog   <= n;
    src_half  <= 4'(4 + $urandom % 4);
    src_start <= 1'b1;
    @(posedge pclk);
    src_start <= 1'b0;
    do @(posedge pclk); while (src_busy === 1'b1);
    repeat (20) @(posedge pclk);
    rd(A_CNT, e, e);
  endtask : ext_case

  // response watcher and watchdog pulse counters
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      cur = notes.pop_front();
      check_rsp(cur, prdata, pslverr);
    end
    if (wd_tick === 1'b1) ticks++;
    if (wd_clear === 1'b1) clears++;
  end

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    finish_test();
  end

  initial begin
    logic [7:0] v;
    int         n;
    {presetn, psel, penable, pwrite, sleep_mode, cwi, wd_base} = 7'h00;
    {paddr, pwdata, src_start, src_tog, src_half} = '0;
    {err_total, compares, ticks, clears} = '0;
    void'($urandom(33126));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CNT, 8'h00, 8'h00);
    rd(A_INTC, 8'h00, 8'h00);
    rd(A_OPT, 8'hFF, 8'hFF);
    rd(A_PORTA, 8'h3F, 8'h3F);
    check_val({2'b00, porta}, 8'h3F);
    apb(1'b0, A_BAD, 32'h0, '{8'h00, 8'h00, 1'b1, 1'b1});
    v = 8'($urandom % 64);
    wr(A_PORTA, v);
    apb(1'b1, A_BAD, 32'h0, '{8'h00, 8'h00, 1'b0, 1'b1});
    rd(A_PORTA, v, v);
    check_val({2'b00, porta}, v);
    wr(A_OPT, 8'h08);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom % 64);
      repeat (i) @(posedge pclk);
      wr(A_CNT, v);
      rd(A_CNT, v, v);
    end
    repeat (36) @(posedge pclk);
    rd(A_CNT, v + 8'h07, v + 8'h0A);
    wr(A_INTC, 8'h20);
    wr(A_CNT, 8'hFE);
    repeat (30) @(posedge pclk);
    irq_is(1'b1);
    rd(A_INTC, 8'h24, 8'h24);
    rd(A_CNT, 8'h04, 8'h06);
    wr(A_INTC, 8'h04);
    irq_is(1'b0);
    rd(A_STAT, 8'h01, 8'h01);
    wr(A_CLR, 8'h01);
    rd(A_STAT, 8'h00, 8'h00);
    wr(A_EN, 8'h01);
    irq_is(1'b0);
    rd(A_INTC, 8'h20, 8'h20);
    wr(A_INTC, 8'h24);
    irq_is(1'b1);
    wr(A_CLR, 8'h01);
    @(posedge pclk);
    sleep_mode <= 1'b1;
    wr(A_CNT, 8'hFF);
    repeat (100) @(posedge pclk);
    rd(A_CNT, 8'hFF, 8'hFF);
    rd(A_STAT, 8'h00, 8'h00);
    sleep_mode <= 1'b0;
    ext_case(8'h28, 8'h05, 8'h03);
    ext_case(8'h38, 8'h05, 8'h03);
    ext_case(8'h20, 8'h08, 8'h02);
    for (int r = 0; r < 8; r++) begin
      wr(A_OPT, 8'(r));
      wr(A_CNT, 8'h00);
      repeat (12 * (2 << r) + 10) @(posedge pclk);
      rd(A_CNT, 8'h02, 8'h04);
    end
    wr(A_CNT, 8'h00);
    for (int r = 0; r < 8; r++) begin
      wr(A_OPT, 8'(8'h08 | r));
      wdb(1);
      repeat (3) @(posedge pclk);
      clears = 0;
      wdt_clear();
      repeat (3) @(posedge pclk);
      ticks = 0;
      wdb((4 << r) - 1);
      repeat (3) @(posedge pclk);
      check_val(8'(ticks), 8'h03);
      check_val(8'(clears), 8'h01);
    end
    wdt_clear();
    wr(A_OPT, 8'h07);
    repeat (3) @(posedge pclk);
    ticks = 0;
    wdb(4);
    repeat (3) @(posedge pclk);
    check_val(8'(ticks), 8'h04);
    n = 0;
    repeat (40) begin
      @(negedge pclk);
      if (icyc === 1'b1) n++;
    end
    check_val(8'(n), 8'h0A);
    finish_test();
  end
endmodule : tb
